// ### verilog/bmrm_pkg.sv
// Purpose: Shared constants and types of the rate match receive path
// Assumes: Symbols are 9 bits, control flag above an 8-bit byte
// Notes: Raw low-latency words use the full 10-bit field when width10 is set, else the low byte only
package bmrm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Symbol encodings
  localparam logic [8:0] BMRM_SKIP_DEFAULT = 9'h1_BC;
  localparam logic [8:0] BMRM_UNDERFLOW_CHAR = 9'h1_FE;

  ////////////////////////////////////////////////////////////////////////////
  // Cluster adjustment limits
  localparam logic [3:0] BMRM_MAX_DELETE = 4'h4;
  localparam logic [3:0] BMRM_MAX_INSERT = 4'h4;
  localparam logic [3:0] BMRM_CLUSTER_CAP = 4'h5;
  localparam logic [3:0] BMRM_MIN_LEFT = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and synchroniser depth
  localparam logic [3:0] BMRM_RUN_RESET = 4'h0;
  localparam logic BMRM_FLAG_RESET = 1'b0;
  localparam int BMRM_SYNC_STAGES = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Word travelling from the rate matcher to the output buffer
  typedef struct packed {
    logic fullFlag;
    logic emptyFlag;
    logic [9:0] word;
  } bmrm_word_t;

  // Entry held in the rate match storage
  typedef struct packed {
    logic fullFlag;
    logic [8:0] sym;
  } bmrm_entry_t;

endpackage : bmrm_pkg

// ### verilog/bmrm_gray_sync.sv
// Purpose: Two-stage synchroniser for a gray-coded pointer
// Assumes: Source pointer changes by one gray step at a time
// Notes: First stage is read only by the second stage
`timescale 1ns/10ps
module bmrm_gray_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rstSync_b,
  input wire logic [W-1:0] grayIn,
  output logic [W-1:0] grayOut
);

  logic [W-1:0] stage1;

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      stage1 <= '0;
      grayOut <= '0;
    end else begin
      stage1 <= grayIn;
      grayOut <= stage1;
    end
  end

endmodule : bmrm_gray_sync

// ### verilog/bmrm_skid_buf.sv
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Writer holds its word until ready is seen
// Notes: All outputs come from flip-flops
`timescale 1ns/10ps
module bmrm_skid_buf #(
  parameter int W = 12
) (
  input wire logic clk,
  input wire logic rstSync_b,
  input wire logic inValid,
  input wire logic [W-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [W-1:0] outData,
  input wire logic outReady
);

  logic [W-1:0] tail;
  logic tailValid;
  logic take;
  logic give;

  assign take = inValid && inReady;
  assign give = outValid && outReady;

  // Head stage feeds the consumer; tail holds a word during a stall
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      outValid <= 1'b0;
      outData <= '0;
      tailValid <= 1'b0;
      tail <= '0;
      inReady <= 1'b1;
    end else begin
      if (!outValid || give) begin
        if (tailValid) begin
          outData <= tail;
          outValid <= 1'b1;
          tailValid <= take;
          tail <= inData;
          inReady <= !take;
        end else begin
          outValid <= take;
          outData <= inData;
        end
      end else if (take) begin
        tail <= inData;
        tailValid <= 1'b1;
        inReady <= 1'b0;
      end
      if (tailValid && (!outValid || give) && !take) begin
        inReady <= 1'b1;
      end
    end
  end

endmodule : bmrm_skid_buf

// ### verilog/bmrm_rate_match.sv
// Purpose: Receive rate match stage with generic-mode datapath options
// Assumes: One clock; write and read sides are strobed in that clock
// Notes: Pointers cross between sides gray-coded through two stages
`timescale 1ns/10ps
module bmrm_rate_match #(
  parameter int DEPTH_LOG2 = 3,
  parameter logic [8:0] SKIP_PATTERN = bmrm_pkg::BMRM_SKIP_DEFAULT,
  parameter int HIGH_MARK = 6,
  parameter int LOW_MARK = 2
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic rxValid,
  input wire logic [9:0] rxWord,
  output logic lowLatReady,
  input wire logic lowLatency,
  input wire logic width10,
  input wire logic codecEnable,
  input wire logic txElecIdle,
  input wire logic rxSignalRaw,
  output logic txDriverOe,
  output logic rxSignalDetect,
  output logic outValid,
  output logic [9:0] outWord,
  output logic outFull,
  output logic outEmpty,
  input wire logic outReady
);

  localparam int DEPTH = 1 << DEPTH_LOG2;
  localparam int PW = DEPTH_LOG2 + 1;
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
  localparam logic [PW-1:0] HIGH_P = PW'(HIGH_MARK);
  localparam logic [PW-1:0] LOW_P = PW'(LOW_MARK);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rstMeta_b;
  logic rstSync_b;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_b <= 1'b0;
      rstSync_b <= 1'b0;
    end else begin
      rstMeta_b <= 1'b1;
      rstSync_b <= rstMeta_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage and pointers
  bmrm_pkg::bmrm_entry_t mem [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [PW-1:0] wrGray;
  logic [PW-1:0] rdGray;
  logic [PW-1:0] wrGraySync;
  logic [PW-1:0] rdGraySync;
  logic [PW-1:0] wrPtrSeen;
  logic [PW-1:0] rdPtrSeen;
  logic [PW-1:0] wrLevel;
  logic [PW-1:0] rdLevel;
  logic fifoFull;
  logic fifoEmpty;

  function automatic logic [PW-1:0] grayToBin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = '0;
    for (int i = PW - 1; i >= 0; i--) begin
      b[i] = (i == PW - 1) ? g[i] : (b[i+1] ^ g[i]);
    end
    return b;
  endfunction : grayToBin

  assign wrGray = wrPtr ^ (wrPtr >> 1);
  assign rdGray = rdPtr ^ (rdPtr >> 1);

  bmrm_gray_sync #(.W(PW)) u_wrToRd (
    .clk(ref_clk),
    .rstSync_b(rstSync_b),
    .grayIn(wrGray),
    .grayOut(wrGraySync)
  );

  bmrm_gray_sync #(.W(PW)) u_rdToWr (
    .clk(ref_clk),
    .rstSync_b(rstSync_b),
    .grayIn(rdGray),
    .grayOut(rdGraySync)
  );

  // Levels seen through the crossing are conservative on both sides
  assign rdPtrSeen = grayToBin(rdGraySync);
  assign wrPtrSeen = grayToBin(wrGraySync);
  assign wrLevel = PW'(wrPtr - rdPtrSeen);
  assign rdLevel = PW'(wrPtrSeen - rdPtr);
  assign fifoFull = (wrLevel == DEPTH_P);
  assign fifoEmpty = (rdLevel == '0);

  ////////////////////////////////////////////////////////////////////////////
  // Write side: cluster tracking, deletion, overflow
  logic [8:0] rxSym;
  logic rxIsSkip;
  logic dropSkip;
  logic doWrite;
  logic [3:0] wrRun;
  logic [3:0] wrDel;
  logic fullPend;

  assign rxSym = rxWord[8:0];
  assign rxIsSkip = (rxSym == SKIP_PATTERN);
  // Delete only while one skip of the cluster is already stored
  assign dropSkip = rxIsSkip && (wrRun >= bmrm_pkg::BMRM_MIN_LEFT) &&
                    (wrDel < bmrm_pkg::BMRM_MAX_DELETE) &&
                    (wrLevel >= HIGH_P);
  assign doWrite = rxValid && !lowLatency && !dropSkip && !fifoFull;

  always_ff @(posedge ref_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      wrRun <= bmrm_pkg::BMRM_RUN_RESET;
      wrDel <= bmrm_pkg::BMRM_RUN_RESET;
    end else if (rxValid && !lowLatency) begin
      if (!rxIsSkip) begin
        wrRun <= bmrm_pkg::BMRM_RUN_RESET;
        wrDel <= bmrm_pkg::BMRM_RUN_RESET;
      end else if (dropSkip) begin
        wrDel <= 4'(wrDel + 4'h1);
      end else if (!fifoFull && wrRun != 4'hF) begin
        wrRun <= 4'(wrRun + 4'h1);
      end
    end
  end

  // Byte meeting a full store is lost; next stored byte carries the flag
  always_ff @(posedge ref_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      fullPend <= bmrm_pkg::BMRM_FLAG_RESET;
    end else if (rxValid && !lowLatency && !dropSkip) begin
      fullPend <= fifoFull;
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      wrPtr <= '0;
    end else if (doWrite) begin
      wrPtr <= PW'(wrPtr + 1'b1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (doWrite) begin
      mem[wrPtr[DEPTH_LOG2-1:0]] <= '{fullFlag: fullPend, sym: rxSym};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read side: insertion, underflow
  bmrm_pkg::bmrm_entry_t head;
  logic bufReady;
  logic lastSkip;
  logic emptyDone;
  logic [3:0] rdRun;
  logic [3:0] rdIns;
  logic addSkip;
  logic addIdle;
  logic doPop;
  logic emit;
  bmrm_pkg::bmrm_word_t emitWord;
  bmrm_pkg::bmrm_word_t bufIn;
  bmrm_pkg::bmrm_word_t bufOut;
  logic bufValid;

  assign head = mem[rdPtr[DEPTH_LOG2-1:0]];
  // Repeat a skip while the store runs low and the cluster has room
  assign addSkip = bufReady && !lowLatency && !fifoEmpty && lastSkip &&
                   (rdLevel < LOW_P) &&
                   (rdIns < bmrm_pkg::BMRM_MAX_INSERT) &&
                   (4'(rdRun + 4'h1) < bmrm_pkg::BMRM_CLUSTER_CAP);
  assign addIdle = bufReady && !lowLatency && fifoEmpty && !emptyDone;
  assign doPop = bufReady && !lowLatency && !fifoEmpty && !addSkip;
  assign emit = addSkip || addIdle || doPop;

  always_comb begin
    emitWord = '0;
    if (addIdle) begin
      emitWord.word = {1'b0, bmrm_pkg::BMRM_UNDERFLOW_CHAR};
      emitWord.emptyFlag = 1'b1;
    end else if (addSkip) begin
      emitWord.word = {1'b0, SKIP_PATTERN};
    end else begin
      emitWord.word = {1'b0, head.sym};
      emitWord.fullFlag = head.fullFlag;
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      rdPtr <= '0;
    end else if (doPop) begin
      rdPtr <= PW'(rdPtr + 1'b1);
    end
  end

  // One underflow character per emptying, rearmed by the next real byte
  always_ff @(posedge ref_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      emptyDone <= 1'b1;
    end else if (addIdle) begin
      emptyDone <= 1'b1;
    end else if (doPop) begin
      emptyDone <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      lastSkip <= 1'b0;
      rdRun <= bmrm_pkg::BMRM_RUN_RESET;
      rdIns <= bmrm_pkg::BMRM_RUN_RESET;
    end else if (addIdle) begin
      lastSkip <= 1'b0;
      rdRun <= bmrm_pkg::BMRM_RUN_RESET;
      rdIns <= bmrm_pkg::BMRM_RUN_RESET;
    end else if (addSkip) begin
      rdRun <= 4'(rdRun + 4'h1);
      rdIns <= 4'(rdIns + 4'h1);
    end else if (doPop) begin
      if (head.sym == SKIP_PATTERN) begin
        lastSkip <= 1'b1;
        if (rdRun != 4'hF) begin
          rdRun <= 4'(rdRun + 4'h1);
        end
      end else begin
        lastSkip <= 1'b0;
        rdRun <= bmrm_pkg::BMRM_RUN_RESET;
        rdIns <= bmrm_pkg::BMRM_RUN_RESET;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Path select and width
  always_comb begin
    bufIn = emitWord;
    if (lowLatency) begin
      bufIn = '0;
      bufIn.word = width10 ? rxWord : {2'b00, rxWord[7:0]};
    end
  end

  assign bufValid = lowLatency ? rxValid : emit;

  bmrm_skid_buf #(.W($bits(bmrm_pkg::bmrm_word_t))) u_outBuf (
    .clk(ref_clk),
    .rstSync_b(rstSync_b),
    .inValid(bufValid),
    .inData(bufIn),
    .inReady(bufReady),
    .outValid(outValid),
    .outData(bufOut),
    .outReady(outReady)
  );

  assign lowLatReady = bufReady;
  assign outWord = bufOut.word;
  assign outFull = bufOut.fullFlag;
  assign outEmpty = bufOut.emptyFlag;

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter idle and receiver signal detect
  always_ff @(posedge ref_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      txDriverOe <= 1'b0;
    end else begin
      txDriverOe <= !txElecIdle;
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      rxSignalDetect <= 1'b0;
    end else begin
      rxSignalDetect <= rxSignalRaw && codecEnable && !lowLatency;
    end
  end

endmodule : bmrm_rate_match

// ### tb/bmrm_rate_match_properties.sv
// Purpose: Port checker for the rate match stage
// Assumes: Internal reset copy lags rst_b by two edges
// Notes: Checks other than a_k30 and a_once start three edges after release
`timescale 1ns/10ps
module bmrm_rate_match_chk (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic rxValid,
  input wire logic [9:0] rxWord,
  input wire logic lowLatReady,
  input wire logic lowLatency,
  input wire logic width10,
  input wire logic codecEnable,
  input wire logic txElecIdle,
  input wire logic rxSignalRaw,
  input wire logic txDriverOe,
  input wire logic rxSignalDetect,
  input wire logic outValid,
  input wire logic [9:0] outWord,
  input wire logic outFull,
  input wire logic outEmpty,
  input wire logic outReady
);
  logic [2:0] up;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      up <= 3'h0;
    end else begin
      up <= {up[1:0], 1'b1};
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_det;
    up[2] |=> rxSignalDetect ==
      $past(rxSignalRaw && codecEnable && !lowLatency);
  endproperty
  a_det: assert property (p_det) else $error("detect wrong");
  property p_oe;
    up[2] |=> txDriverOe == !$past(txElecIdle);
  endproperty
  a_oe: assert property (p_oe) else $error("driver enable wrong");
  property p_hold;
    up[2] && outValid && !outReady |=>
      outValid && $stable(outWord) && $stable({outFull, outEmpty});
  endproperty
  a_hold: assert property (p_hold) else $error("word not held");
  property p_k30;
    outValid && outEmpty |-> outWord[8:0] == 9'h1_FE;
  endproperty
  a_k30: assert property (p_k30) else $error("empty mark wrong");
  property p_once;
    outValid && outReady && outEmpty |=> !(outValid && outEmpty);
  endproperty
  a_once: assert property (p_once) else $error("repeated fill");
  property p_ll;
    up[2] && lowLatency && width10 && rxValid && lowLatReady && !outValid
      |=> outValid && outWord == $past(rxWord);
  endproperty
  a_ll: assert property (p_ll) else $error("bypass word wrong");
  property p_l8;
    up[2] && lowLatency && !width10 && rxValid && lowLatReady && !outValid
      |=> outValid && outWord == {2'b00, $past(rxWord[7:0])};
  endproperty
  a_l8: assert property (p_l8) else $error("narrow word wrong");
  property p_rdy;
    up[2] && !lowLatReady |-> outValid;
  endproperty
  a_rdy: assert property (p_rdy) else $error("stall while empty");
  c_full: cover property (outValid && outFull);
  c_empty: cover property (outValid && outEmpty);
  c_ll: cover property (lowLatency && outValid && outReady);
endmodule : bmrm_rate_match_chk

bind bmrm_rate_match bmrm_rate_match_chk u_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .rxValid(rxValid),
  .rxWord(rxWord), .lowLatReady(lowLatReady), .lowLatency(lowLatency),
  .width10(width10), .codecEnable(codecEnable), .txElecIdle(txElecIdle),
  .rxSignalRaw(rxSignalRaw), .txDriverOe(txDriverOe),
  .rxSignalDetect(rxSignalDetect), .outValid(outValid),
  .outWord(outWord), .outFull(outFull), .outEmpty(outEmpty),
  .outReady(outReady)
);

// ### tb/bmrm_sink.sv
// Purpose: Fabric-side consumer of output words
// Assumes: Takes a word at an edge with valid and ready high
// Notes: Stalls every fourth cycle, and always while hold is high
`timescale 1ns/10ps
module bmrm_sink (
  input wire logic ref_clk,
  input wire logic hold,
  input wire logic outValid,
  input wire logic [9:0] outWord,
  input wire logic outFull,
  input wire logic outEmpty,
  output logic outReady
);
  bmrm_pkg::bmrm_word_t got[$];
  logic [1:0] beat = 2'h0;
  initial outReady = 1'b0;
  always @(posedge ref_clk) begin
    if (outValid && outReady) begin
      got.push_back({outFull, outEmpty, outWord});
    end
    beat <= beat + 2'h1;
    outReady <= !hold && beat != 2'h2;
  end
endmodule : bmrm_sink

// ### tb/tb.sv
// Purpose: Self-checking bench for the rate match stage
// Assumes: Sink model records every word taken
// Notes: Recorded words are compared after each test except the options test, which checks the ports directly
`timescale 1ns/10ps
module tb;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic rxValid = 1'b0;
  logic [9:0] rxWord = 10'h000;
  logic lowLatency = 1'b0;
  logic width10 = 1'b1;
  logic codecEnable = 1'b1;
  logic txElecIdle = 1'b0;
  logic rxSignalRaw = 1'b0;
  logic hold = 1'b0;
  logic lowLatReady, txDriverOe, rxSignalDetect, e;
  logic outValid, outFull, outEmpty, outReady;
  logic [9:0] outWord;
  logic [9:0] skip = {1'b0, bmrm_pkg::BMRM_SKIP_DEFAULT};
  int bad_count = 0;
  int comparisons = 0;
  int k, n;
  bmrm_pkg::bmrm_word_t q[$];

  always #25 ref_clk = ~ref_clk;

  bmrm_rate_match uut (
    .ref_clk(ref_clk), .rst_b(rst_b), .rxValid(rxValid),
    .rxWord(rxWord), .lowLatReady(lowLatReady), .lowLatency(lowLatency),
    .width10(width10), .codecEnable(codecEnable), .txElecIdle(txElecIdle),
    .rxSignalRaw(rxSignalRaw), .txDriverOe(txDriverOe),
    .rxSignalDetect(rxSignalDetect), .outValid(outValid),
    .outWord(outWord), .outFull(outFull), .outEmpty(outEmpty),
    .outReady(outReady)
  );
  bmrm_sink u_sink (
    .ref_clk(ref_clk), .hold(hold), .outValid(outValid),
    .outWord(outWord), .outFull(outFull), .outEmpty(outEmpty),
    .outReady(outReady)
  );

  task automatic chk(input string s, input logic [9:0] x, logic [9:0] g);
    comparisons++;
    if (g !== x) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", s, x, g);
    end
  endtask : chk
  task automatic want(input string s, input logic c);
    chk(s, 10'h001, {9'h000, c});
  endtask : want
  task automatic send(input logic [9:0] w);
    rxValid <= 1'b1;
    rxWord <= w;
    @(posedge ref_clk);
    while (lowLatency && !lowLatReady) @(posedge ref_clk);
  endtask : send
  task automatic quiet();
    rxValid <= 1'b0;
  endtask : quiet
  task automatic take(input int c);
    repeat (c) @(posedge ref_clk);
    q = u_sink.got;
    u_sink.got.delete();
    k = 0;
    n = 0;
    foreach (q[i]) begin
      k += int'(q[i].word[8:0] == skip[8:0]);
      n += int'(q[i].fullFlag);
    end
  endtask : take
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  initial begin
    repeat (4000) @(posedge ref_clk);
    bad_count++;
    results();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    chk("rst oe", 10'h000, {9'h000, txDriverOe});
    chk("rst valid", 10'h000, {9'h000, outValid});
    chk("rst ready", 10'h001, {9'h000, lowLatReady});
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 16; i++) begin
      {lowLatency, txElecIdle, codecEnable, rxSignalRaw} <= i[3:0];
      repeat (2) @(posedge ref_clk);
      e = rxSignalRaw && codecEnable && !lowLatency;
      chk("oe", {9'h000, !txElecIdle}, {9'h000, txDriverOe});
      chk("det", {9'h000, e}, {9'h000, rxSignalDetect});
    end
    $display("test options done");
    {lowLatency, txElecIdle, codecEnable} <= 3'h4;
    take(4);
    for (int i = 0; i < 6; i++) send(10'h3A0 + 10'(i));
    width10 <= 1'b0;
    send(10'h2C3);
    quiet();
    take(20);
    for (int i = 0; i < 6; i++) begin
      chk("low", 10'h3A0 + 10'(i), q[i].word);
    end
    chk("narrow", 10'h0C3, q[6].word);
    $display("test bypass done");
    lowLatency <= 1'b0;
    width10 <= 1'b1;
    take(10);
    send(10'h041);
    quiet();
    take(20);
    chk("data", 10'h041, {1'b0, q[0].word[8:0]});
    chk("fill", 10'h1FE, {1'b0, q[1].word[8:0]});
    want("empty", q[1].emptyFlag && !q[0].emptyFlag && q.size() == 2);
    // Skip popped with one byte left behind it: store runs low, not empty
    send(skip);
    send(10'h052);
    quiet();
    take(30);
    chk("insert", 10'h004, 10'(k));
    want("end", q[q.size() - 1].emptyFlag);
    $display("test empty done");
    hold <= 1'b1;
    for (int i = 0; i < 9; i++) send(10'h060 + 10'(i));
    quiet();
    repeat (12) @(posedge ref_clk);
    for (int i = 0; i < 5; i++) send(skip);
    hold <= 1'b0;
    quiet();
    // Let the store drain below full before the closing bytes
    repeat (8) @(posedge ref_clk);
    for (int i = 0; i < 3; i++) send(10'h070 + 10'(i));
    quiet();
    take(60);
    chk("delete", 10'h001, 10'(k));
    chk("no full", 10'h000, 10'(n));
    chk("words", 10'h00E, 10'(q.size()));
    $display("test delete done");
    hold <= 1'b1;
    for (int i = 0; i < 16; i++) send(10'h080 + 10'(i));
    quiet();
    repeat (4) @(posedge ref_clk);
    hold <= 1'b0;
    repeat (20) @(posedge ref_clk);
    send(10'h09F);
    quiet();
    take(60);
    chk("full n", 10'h001, 10'(n));
    k = 'h7F;
    foreach (q[i]) begin
      if (!q[i].emptyFlag) begin
        e = q[i].word[8:0] != k + 1;
        chk("full", {9'h000, e}, {9'h000, q[i].fullFlag});
        k = q[i].word[8:0];
      end
    end
    $display("test full done");
    results();
  end
endmodule : tb
